//--- design/ocd_top.sv
// Operator command decoder: modes, overrides, interlocks, handles, cycle start
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ocd_top #(
    parameter int unsigned WHEELS_MAX = 2
) (
    input  wire logic                               clk_i,
    input  wire logic                               rstn_i,
    input  wire ocd_pkg::ocd_cmd_t                  cmd_i,
    input  wire logic [WHEELS_MAX-1:0]              pulse_gen_phase_one_i,
    input  wire logic [WHEELS_MAX-1:0]              pulse_gen_phase_two_i,
    input  wire logic                               cycle_end_i,
    input  wire logic [7:0]                         addr_i,
    input  wire logic [31:0]                        wdata_i,
    input  wire logic                               wr_i,
    input  wire logic                               rd_i,
    output logic      [31:0]                        rdata_o,
    output ocd_pkg::ocd_mode_t                      mode_o,
    output logic      [15:0]                        jog_ovr_o,
    output logic      [1:0][15:0]                   jog_rate_o,
    output logic      [1:0]                         dir_axis_block_pos_o,
    output logic      [1:0]                         dir_axis_block_neg_o,
    output ocd_pkg::ocd_move_t [WHEELS_MAX-1:0]     hmove_o,
    output logic                                    cycle_start_o,
    output logic                                    feed_enable_o,
    output logic                                    feed_held_o
);
    // ==========================================================
    // Elaboration check
    if (WHEELS_MAX < 1 || WHEELS_MAX > 2) begin : g_bad_wheels
        $error("WHEELS_MAX must be 1 or 2");
    end

    typedef struct packed {
        ocd_pkg::ocd_cmd_t                      cmd;
        logic                                   start_prev;
        ocd_pkg::ocd_mode_t                     mode;
        ocd_pkg::ocd_cyc_t                      cyc;
        logic                                   cycle_start;
        logic                                   fall_en;
        logic [1:0]                             wheel_cnt;
        logic [6:0]                             mag_m;
        logic [9:0]                             mag_n;
        logic [1:0][15:0]                       rate;
        ocd_pkg::ocd_move_t [WHEELS_MAX-1:0]    move;
        logic [31:0]                            rdata;
    } ocd_top_state_t;

    ocd_top_state_t st_r;
    ocd_top_state_t st_nxt;

    logic [WHEELS_MAX-1:0] q_step;
    logic [WHEELS_MAX-1:0] q_dir;
    logic [15:0]           ovr_pct;

    // ==========================================================
    // Decoding helpers
    function automatic ocd_pkg::ocd_mode_t decode_mode(input logic [7:0] b);
        logic [2:0] op;
        op = b[ocd_pkg::OP_SEL_LSB +: 3];
        if (op == ocd_pkg::OP_DATA_IN) begin
            return ocd_pkg::MODE_MDI;
        end else if (op == ocd_pkg::OP_MEMORY) begin
            return b[ocd_pkg::REMOTE_BIT] ? ocd_pkg::MODE_RMT : ocd_pkg::MODE_MEM;
        end
        return ocd_pkg::MODE_NONE;
    endfunction

    // Wheel one has a third select bit; any code beyond 01 and 10 selects nothing
    function automatic logic [1:0] wheel_axis(input logic [7:0] b, input int w);
        logic [2:0] sel;
        sel = (w == 0) ? b[ocd_pkg::WHEEL1_SEL_LSB +: 3]
                       : {1'b0, b[ocd_pkg::WHEEL2_SEL_LSB +: 2]};
        case (sel)
            3'h1:    return 2'b01;
            3'h2:    return 2'b10;
            default: return 2'b00;
        endcase
    endfunction

    function automatic logic [9:0] scale_amt(input logic lo, input logic hi,
                                             input logic [6:0] m, input logic [9:0] n);
        unique case ({lo, hi})
            2'b00: return ocd_pkg::SCALE_X1;
            2'b01: return ocd_pkg::SCALE_X10;
            2'b10: return {3'h0, m};
            2'b11: return n;
        endcase
    endfunction

    // ==========================================================
    // Wheels and override decoder
    for (genvar w = 0; w < WHEELS_MAX; w++) begin : g_wheel
        ocd_quad u_quad (
            .clk_i                 (clk_i),
            .rstn_i                (rstn_i),
            .pulse_gen_phase_one_i (pulse_gen_phase_one_i[w]),
            .pulse_gen_phase_two_i (pulse_gen_phase_two_i[w]),
            .step_o                (q_step[w]),
            .dir_o                 (q_dir[w])
        );
    end

    ocd_ovr u_ovr (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .raw_n_i ({st_r.cmd.jog_hi, st_r.cmd.jog_lo}),
        .pct_o   (ovr_pct)
    );

    // ==========================================================
    // Next state
    logic start_fall;
    logic hold_n;
    logic auto_ok;

    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd = cmd_i;
        st_nxt.start_prev = st_r.cmd.start_byte[ocd_pkg::START_BIT];
        st_nxt.mode = decode_mode(st_r.cmd.op_byte);
        st_nxt.cycle_start = 1'b0;
        st_nxt.rdata = 32'h0000_0000;

        start_fall = st_r.start_prev && !st_r.cmd.start_byte[ocd_pkg::START_BIT];
        hold_n = st_r.cmd.hold_byte[ocd_pkg::HOLD_BIT];
        auto_ok = (st_r.mode != ocd_pkg::MODE_NONE);

        // Cycle sequencing; an end request wins over a hold change
        unique case (st_r.cyc)
            ocd_pkg::CYC_IDLE: begin
                if (start_fall && st_r.fall_en && auto_ok && hold_n) begin
                    st_nxt.cyc = ocd_pkg::CYC_RUN;
                    st_nxt.cycle_start = 1'b1;
                end
            end
            ocd_pkg::CYC_RUN: begin
                if (cycle_end_i) begin
                    st_nxt.cyc = ocd_pkg::CYC_IDLE;
                end else if (!hold_n) begin
                    st_nxt.cyc = ocd_pkg::CYC_HOLD;
                end
            end
            ocd_pkg::CYC_HOLD: begin
                if (cycle_end_i) begin
                    st_nxt.cyc = ocd_pkg::CYC_IDLE;
                end else if (hold_n) begin
                    st_nxt.cyc = ocd_pkg::CYC_RUN;
                end
            end
            default: st_nxt.cyc = ocd_pkg::CYC_IDLE;
        endcase

        // Handle moves; a blocked direction drops the pulse rather than queue it
        for (int w = 0; w < WHEELS_MAX; w++) begin
            st_nxt.move[w].axis = wheel_axis(st_r.cmd.wheel_byte, w);
            st_nxt.move[w].dir = q_dir[w];
            st_nxt.move[w].amount = scale_amt(st_r.cmd.handle_scale_sel_lo,
                                              st_r.cmd.handle_scale_sel_hi,
                                              st_r.mag_m, st_r.mag_n);
            st_nxt.move[w].valid = q_step[w]
                && (w < int'(st_r.wheel_cnt))
                && (st_nxt.move[w].axis != 2'b00)
                && ((st_nxt.move[w].axis & (q_dir[w] ? st_r.cmd.pos_block[1:0]
                                                     : st_r.cmd.neg_block[1:0])) == 2'b00);
        end

        // Register writes; out-of-range values leave the old setting
        if (wr_i) begin
            case (addr_i)
                ocd_pkg::ADDR_CFG: begin
                    st_nxt.fall_en = wdata_i[ocd_pkg::CFG_FALL_EN_BIT];
                    if (wdata_i[ocd_pkg::CFG_WHEELS_LSB +: 2] != 2'h0
                        && 32'(wdata_i[ocd_pkg::CFG_WHEELS_LSB +: 2]) <= WHEELS_MAX) begin
                        st_nxt.wheel_cnt = wdata_i[ocd_pkg::CFG_WHEELS_LSB +: 2];
                    end
                end
                ocd_pkg::ADDR_MAG_M: begin
                    if (wdata_i[31:0] != 32'h0000_0000 && wdata_i[31:0] <= 32'(ocd_pkg::MAG_M_MAX)) begin
                        st_nxt.mag_m = wdata_i[6:0];
                    end
                end
                ocd_pkg::ADDR_MAG_N: begin
                    if (wdata_i[31:0] != 32'h0000_0000 && wdata_i[31:0] <= 32'(ocd_pkg::MAG_N_MAX)) begin
                        st_nxt.mag_n = wdata_i[9:0];
                    end
                end
                ocd_pkg::ADDR_RATE1: st_nxt.rate[0] = wdata_i[15:0];
                ocd_pkg::ADDR_RATE2: st_nxt.rate[1] = wdata_i[15:0];
                default: ;
            endcase
        end

        // Reads answer in the next cycle; unmapped addresses read zero
        if (rd_i) begin
            case (addr_i)
                ocd_pkg::ADDR_CFG:    st_nxt.rdata = {29'h0, st_r.wheel_cnt, st_r.fall_en};
                ocd_pkg::ADDR_MAG_M:  st_nxt.rdata = {25'h0, st_r.mag_m};
                ocd_pkg::ADDR_MAG_N:  st_nxt.rdata = {22'h0, st_r.mag_n};
                ocd_pkg::ADDR_RATE1:  st_nxt.rdata = {16'h0, st_r.rate[0]};
                ocd_pkg::ADDR_RATE2:  st_nxt.rdata = {16'h0, st_r.rate[1]};
                ocd_pkg::ADDR_STATUS: st_nxt.rdata = {20'h0, st_r.cmd.neg_block[1:0],
                                                      st_r.cmd.pos_block[1:0], 1'b0,
                                                      st_r.cyc, st_r.mode};
                ocd_pkg::ADDR_OVR:    st_nxt.rdata = {16'h0, ovr_pct};
                default:              st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
            st_r.mode <= ocd_pkg::MODE_NONE;
            st_r.cyc <= ocd_pkg::CYC_IDLE;
            st_r.fall_en <= ocd_pkg::RST_FALL_EN;
            st_r.wheel_cnt <= ocd_pkg::RST_WHEELS;
            st_r.mag_m <= ocd_pkg::RST_MAG_M;
            st_r.mag_n <= ocd_pkg::RST_MAG_N;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o              = st_r.rdata;
    assign mode_o               = st_r.mode;
    assign jog_ovr_o            = ovr_pct;
    assign jog_rate_o           = st_r.rate;
    assign dir_axis_block_pos_o = st_r.cmd.pos_block[1:0];
    assign dir_axis_block_neg_o = st_r.cmd.neg_block[1:0];
    assign hmove_o              = st_r.move;
    assign cycle_start_o        = st_r.cycle_start;
    assign feed_enable_o        = (st_r.cyc == ocd_pkg::CYC_RUN);
    assign feed_held_o          = (st_r.cyc == ocd_pkg::CYC_HOLD);

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_release;
        $fell(st_r.cmd.start_byte[ocd_pkg::START_BIT]);
    endsequence

    sequence s_armed;
        st_r.cyc == ocd_pkg::CYC_IDLE && st_r.fall_en && st_r.mode != ocd_pkg::MODE_NONE
            && st_r.cmd.hold_byte[ocd_pkg::HOLD_BIT];
    endsequence

    mode_data_in_a: assert property (
        st_r.cmd.op_byte[2:0] == 3'h0 |=> mode_o == ocd_pkg::MODE_MDI
    ) else $error("mode 000 did not give data input");

    mode_remote_a: assert property (
        st_r.cmd.op_byte[2:0] == 3'h1 && st_r.cmd.op_byte[5]
            |=> mode_o == ocd_pkg::MODE_RMT
    ) else $error("mode 001 with remote did not give remote");

    start_fall_a: assert property (
        s_armed ##0 s_release |=> cycle_start_o ##1 (!cycle_start_o && feed_enable_o)
    ) else $error("falling start did not begin the cycle");

    start_gate_a: assert property (
        cycle_start_o |-> !$past(st_r.cmd.start_byte[ocd_pkg::START_BIT]) && $past(st_r.fall_en)
    ) else $error("cycle started without enabled falling edge");

    hold_stop_a: assert property (
        !st_r.cmd.hold_byte[ocd_pkg::HOLD_BIT] |=> !feed_enable_o
    ) else $error("feed ran while hold input low");

    move_block_a: assert property (
        hmove_o[0].valid |-> (hmove_o[0].axis & (hmove_o[0].dir ? $past(st_r.cmd.pos_block[1:0])
                                                  : $past(st_r.cmd.neg_block[1:0]))) == 2'b00
    ) else $error("handle moved a blocked axis");

    move_scale_a: assert property (
        q_step[0] && {st_r.cmd.handle_scale_sel_lo, st_r.cmd.handle_scale_sel_hi} == 2'b01
            |=> hmove_o[0].amount == 10'h00a
    ) else $error("scale select 01 not times ten");

    mag_range_a: assert property (
        st_r.mag_m != 7'h00 && st_r.mag_n != 10'h000 && st_r.mag_n <= 10'h3e8
    ) else $error("handle magnification out of range");

    wheel_axis_a: assert property (
        q_step[0] && st_r.cmd.wheel_byte[2:0] == 3'h0 |=> !hmove_o[0].valid
    ) else $error("unselected wheel produced a move");

    reset_idle_a: assert property (disable iff (1'b0)
        !rstn_i |=> mode_o == ocd_pkg::MODE_NONE && !feed_enable_o && !cycle_start_o
            && hmove_o[0].valid == 1'b0
    ) else $error("outputs not idle after reset");
endmodule
`default_nettype wire

//--- design/ocd_pkg.sv
// Constants, state codes and carriers of the operator command decoder
package ocd_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_MAG_M  = 8'h04;
    localparam logic [7:0] ADDR_MAG_N  = 8'h08;
    localparam logic [7:0] ADDR_RATE1  = 8'h0c;
    localparam logic [7:0] ADDR_RATE2  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_OVR    = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CFG_FALL_EN_BIT = 0;
    localparam int CFG_WHEELS_LSB  = 1;
    localparam int OP_SEL_LSB      = 0;
    localparam int REMOTE_BIT      = 5;
    localparam int WHEEL1_SEL_LSB  = 0;
    localparam int WHEEL2_SEL_LSB  = 4;
    localparam int START_BIT       = 2;
    localparam int HOLD_BIT        = 5;
    localparam int ST_CYC_LSB      = 4;
    localparam int ST_POS_LSB      = 8;
    localparam int ST_NEG_LSB      = 10;

    // ==========================================================
    // Reset values and limits
    localparam logic       RST_FALL_EN = 1'b1;
    localparam logic [1:0] RST_WHEELS  = 2'h2;
    localparam logic [6:0] RST_MAG_M   = 7'h01;
    localparam logic [9:0] RST_MAG_N   = 10'h001;
    localparam logic [6:0] MAG_M_MAX   = 7'h7f;
    localparam logic [9:0] MAG_N_MAX   = 10'h3e8;
    localparam logic [9:0] SCALE_X1    = 10'h001;
    localparam logic [9:0] SCALE_X10   = 10'h00a;
    localparam logic [2:0] OP_DATA_IN  = 3'h0;
    localparam logic [2:0] OP_MEMORY   = 3'h1;

    // ==========================================================
    // Codes and carriers
    typedef enum logic [3:0] {
        MODE_NONE = 4'b0001,
        MODE_MDI  = 4'b0010,
        MODE_MEM  = 4'b0100,
        MODE_RMT  = 4'b1000
    } ocd_mode_t;

    typedef enum logic [2:0] {
        CYC_IDLE = 3'b001,
        CYC_RUN  = 3'b010,
        CYC_HOLD = 3'b100
    } ocd_cyc_t;

    // Command bytes as the sequence controller drives them
    typedef struct packed {
        logic [7:0] op_byte;
        logic [7:0] jog_lo;
        logic [7:0] jog_hi;
        logic [7:0] pos_block;
        logic [7:0] neg_block;
        logic [7:0] wheel_byte;
        logic [7:0] start_byte;
        logic [7:0] hold_byte;
        logic       handle_scale_sel_lo;
        logic       handle_scale_sel_hi;
    } ocd_cmd_t;

    // One handle move: axis one-hot, dir 1 is positive
    typedef struct packed {
        logic       valid;
        logic [1:0] axis;
        logic       dir;
        logic [9:0] amount;
    } ocd_move_t;

endpackage

//--- design/ocd_quad.sv
// Quadrature decoder for one manual pulse wheel
`timescale 1ns/1ps
`default_nettype none
module ocd_quad (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic pulse_gen_phase_one_i,
    input  wire logic pulse_gen_phase_two_i,
    output logic      step_o,
    output logic      dir_o
);
    typedef struct packed {
        logic a_r;
        logic b_r;
        logic step;
        logic dir;
    } ocd_quad_state_t;

    ocd_quad_state_t st_r;
    ocd_quad_state_t st_nxt;

    // ==========================================================
    // Phase tracking
    always_comb begin
        st_nxt     = st_r;
        st_nxt.a_r = pulse_gen_phase_one_i;
        st_nxt.b_r = pulse_gen_phase_two_i;
        // One phase changing is a step; both at once is noise and is dropped
        st_nxt.step = (pulse_gen_phase_one_i ^ st_r.a_r) ^ (pulse_gen_phase_two_i ^ st_r.b_r);
        st_nxt.dir  = st_r.a_r ^ pulse_gen_phase_two_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign step_o = st_r.step;
    assign dir_o  = st_r.dir;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    quad_step_a: assert property (
        $past(rstn_i) && (pulse_gen_phase_one_i != st_r.a_r)
            && (pulse_gen_phase_two_i == st_r.b_r) |=> step_o
    ) else $error("single phase change gave no step");

    quad_glitch_a: assert property (
        (pulse_gen_phase_one_i != st_r.a_r) && (pulse_gen_phase_two_i != st_r.b_r) |=> !step_o
    ) else $error("double phase change gave a step");
endmodule
`default_nettype wire

//--- design/ocd_ovr.sv
// Jog override decoder: inverted sixteen bits to hundredths of a percent
`timescale 1ns/1ps
`default_nettype none
module ocd_ovr (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [15:0] raw_n_i,
    output logic      [15:0] pct_o
);
    typedef struct packed {
        logic [15:0] pct;
    } ocd_ovr_state_t;

    ocd_ovr_state_t st_r;
    ocd_ovr_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // All zeros would invert to full scale; it means zero as well
        if (raw_n_i == 16'h0000) begin
            st_nxt.pct = 16'h0000;
        end else begin
            st_nxt.pct = ~raw_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pct_o = st_r.pct;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    ovr_zero_a: assert property (
        (raw_n_i == 16'h0000) || (raw_n_i == 16'hffff) |=> pct_o == 16'h0000
    ) else $error("override extreme not zero");

    ovr_unity_a: assert property (
        raw_n_i == 16'hd8ef |=> pct_o == 16'h2710
    ) else $error("override unity pattern not 100 percent");
endmodule
`default_nettype wire

//--- verification/ocd_panel_model.sv
// Operator panel and pulse wheel model for the command decoder bench
`timescale 1ns/1ps
`default_nettype none
module ocd_panel_model (
    input  wire logic clk_i,
    output logic      ph_a_o,
    output logic      ph_b_o,
    output logic      start_o,
    output logic      hold_n_o
);
    logic [1:0] pos_r = 2'h0;
    initial begin
        start_o = 1'b0;
        hold_n_o = 1'b1;
    end
    // Gray walk: one phase changes per step, a leads b when turning forward
    assign ph_a_o = pos_r[0] ^ pos_r[1];
    assign ph_b_o = pos_r[1];
    task automatic turn(input int n, input logic fwd);
        repeat (n) begin
            @(posedge clk_i);
            pos_r <= fwd ? pos_r + 2'h1 : pos_r - 2'h1;
            repeat (2) @(posedge clk_i);
        end
    endtask
    // Button held for a few cycles, released on the last edge
    task automatic press();
        @(posedge clk_i);
        start_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        start_o <= 1'b0;
    endtask
    task automatic hold(input logic v);
        @(posedge clk_i);
        hold_n_o <= v;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the operator command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cyc_end = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    ocd_pkg::ocd_cmd_t cmd_r = '0;
    ocd_pkg::ocd_cmd_t cmd_w;
    logic ph_a, ph_b, st, hold_n, cstart, fen, fheld, mv_dir;
    logic [31:0] rdata;
    ocd_pkg::ocd_mode_t mode;
    logic [15:0] ovr;
    logic [1:0][15:0] rate;
    logic [1:0] bp, bn, mv_axis;
    logic [9:0] mv_amt;
    ocd_pkg::ocd_move_t [1:0] mv;
    int n_errors = 0;
    int total_checks = 0;
    int n_mv = 0;
    int n_cs = 0;
    int n_w2 = 0;
    // ==========================================
    // Table rows: mode byte, raw override, expected mode
    logic [7:0] r_op [6] = '{8'h00, 8'h01, 8'h21, 8'h02, 8'h20, 8'h07};
    logic [15:0] r_jog [6] = '{16'hffff, 16'hfffe, 16'hd8ef, 16'h0001, 16'h0000, 16'h7fff};
    ocd_pkg::ocd_mode_t r_mode [6] = '{ocd_pkg::MODE_MDI, ocd_pkg::MODE_MEM, ocd_pkg::MODE_RMT,
        ocd_pkg::MODE_NONE, ocd_pkg::MODE_MDI, ocd_pkg::MODE_NONE};
    logic [9:0] r_amt [4] = '{10'h001, 10'h00a, 10'h07f, 10'h3e8};

    always #5 clk_i = ~clk_i;
    always_comb begin
        cmd_w = cmd_r;
        cmd_w.start_byte[2] = st;
        cmd_w.hold_byte[5] = hold_n;
    end
    always @(posedge clk_i) begin
        if (mv[0].valid === 1'b1) begin
            n_mv++;
            mv_dir = mv[0].dir;
            mv_amt = mv[0].amount;
            mv_axis = mv[0].axis;
        end
        if (cstart === 1'b1) n_cs++;
        if (mv[1].valid === 1'b1) n_w2++;
    end

    ocd_panel_model i_panel (.clk_i(clk_i), .ph_a_o(ph_a), .ph_b_o(ph_b), .start_o(st),
        .hold_n_o(hold_n));
    ocd_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_w),
        .pulse_gen_phase_one_i({ph_a, ph_a}), .pulse_gen_phase_two_i({ph_b, ph_b}),
        .cycle_end_i(cyc_end), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .mode_o(mode), .jog_ovr_o(ovr), .jog_rate_o(rate),
        .dir_axis_block_pos_o(bp), .dir_axis_block_neg_o(bn), .hmove_o(mv),
        .cycle_start_o(cstart), .feed_enable_o(fen), .feed_held_o(fheld));

    // ==========================================
    // Shared tasks
    function automatic logic [15:0] ovr_exp(input logic [15:0] r);
        return (r == 16'hffff || r == 16'h0000) ? 16'h0000 : ~r;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk("read data", exp, rdata);
    endtask
    task automatic wait_start();
        for (int i = 0; i < 20 && cstart !== 1'b1; i++) @(posedge clk_i) #1;
        chk("cycle start", 32'h0000_0001, 32'(cstart));
        if (cstart !== 1'b1) report_and_stop();
    endtask
    task automatic settle();
        repeat (5) @(posedge clk_i);
        #1;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        int n0;
        logic d0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1 chk("mode after reset", 32'(ocd_pkg::MODE_NONE), 32'(mode));
        chk("feed after reset", 32'h0000_0000, 32'(fen));
        rreg(ocd_pkg::ADDR_CFG, 32'h0000_0005);
        rreg(ocd_pkg::ADDR_MAG_M, 32'h0000_0001);
        rreg(ocd_pkg::ADDR_MAG_N, 32'h0000_0001);
        rreg(8'h1c, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            cmd_r.op_byte <= r_op[i];
            {cmd_r.jog_hi, cmd_r.jog_lo} <= r_jog[i];
            cmd_r.pos_block <= 8'(i);
            cmd_r.neg_block <= 8'(~i);
            settle();
            chk("mode", 32'(r_mode[i]), 32'(mode));
            chk("override", 32'(ovr_exp(r_jog[i])), 32'(ovr));
            chk("block pos", 32'(i[1:0]), 32'(bp));
            chk("block neg", {30'h0, ~i[1:0]}, 32'(bn));
        end
        rreg(ocd_pkg::ADDR_OVR, 32'h0000_8000);
        wreg(ocd_pkg::ADDR_RATE1, 32'h0000_1234);
        wreg(ocd_pkg::ADDR_RATE2, 32'h0000_00ab);
        settle();
        chk("rate axis 1", 32'h0000_1234, 32'(rate[0]));
        chk("rate axis 2", 32'h0000_00ab, 32'(rate[1]));
        wreg(ocd_pkg::ADDR_CFG, 32'h0000_0001);
        rreg(ocd_pkg::ADDR_CFG, 32'h0000_0005);
        wreg(ocd_pkg::ADDR_MAG_M, 32'h0000_007f);
        wreg(ocd_pkg::ADDR_MAG_M, 32'h0000_0080);
        rreg(ocd_pkg::ADDR_MAG_M, 32'h0000_007f);
        wreg(ocd_pkg::ADDR_MAG_N, 32'h0000_03e8);
        wreg(ocd_pkg::ADDR_MAG_N, 32'h0000_03e9);
        rreg(ocd_pkg::ADDR_MAG_N, 32'h0000_03e8);
        // Handle: every scale code, both axes, then reverse and refusals
        @(posedge clk_i);
        cmd_r.pos_block <= 8'h00;
        cmd_r.neg_block <= 8'h00;
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            cmd_r.handle_scale_sel_lo <= s[1];
            cmd_r.handle_scale_sel_hi <= s[0];
            cmd_r.wheel_byte <= s[0] ? 8'h02 : 8'h01;
            n0 = n_mv;
            i_panel.turn(1, 1'b1);
            settle();
            chk("move count", 32'h0000_0001, 32'(n_mv - n0));
            chk("move amount", 32'(r_amt[s]), 32'(mv_amt));
            chk("move axis", s[0] ? 32'h0000_0002 : 32'h0000_0001, 32'(mv_axis));
        end
        d0 = mv_dir;
        i_panel.turn(1, 1'b0);
        settle();
        chk("move reverse", {31'h0, ~d0}, 32'(mv_dir));
        @(posedge clk_i);
        cmd_r.pos_block <= 8'h03;
        cmd_r.neg_block <= 8'h03;
        n0 = n_mv;
        i_panel.turn(2, 1'b1);
        i_panel.turn(2, 1'b0);
        settle();
        chk("blocked moves", 32'h0000_0000, 32'(n_mv - n0));
        @(posedge clk_i);
        cmd_r.pos_block <= 8'h00;
        cmd_r.neg_block <= 8'h00;
        cmd_r.wheel_byte <= 8'h10;
        i_panel.turn(1, 1'b1);
        settle();
        chk("unselected moves", 32'h0000_0000, 32'(n_mv - n0));
        chk("wheel 2 moves", 32'h0000_0001, 32'(n_w2));
        // Cycle start, hold, end, refusals
        @(posedge clk_i);
        cmd_r.op_byte <= 8'h01;
        settle();
        i_panel.press();
        wait_start();
        chk("feed run", 32'h0000_0001, 32'(fen));
        rreg(ocd_pkg::ADDR_STATUS, 32'h0000_0024);
        i_panel.hold(1'b0);
        settle();
        chk("feed held", 32'h0000_0002, 32'({fheld, fen}));
        i_panel.hold(1'b1);
        settle();
        chk("feed resumed", 32'h0000_0001, 32'(fen));
        n0 = n_cs;
        i_panel.press();
        settle();
        chk("start while running", 32'h0000_0000, 32'(n_cs - n0));
        @(posedge clk_i) cyc_end <= 1'b1;
        @(posedge clk_i) cyc_end <= 1'b0;
        settle();
        chk("feed after end", 32'h0000_0000, 32'(fen));
        wreg(ocd_pkg::ADDR_CFG, 32'h0000_0004);
        i_panel.press();
        settle();
        chk("start disabled", 32'h0000_0000, 32'(n_cs - n0));
        wreg(ocd_pkg::ADDR_CFG, 32'h0000_0005);
        cmd_r.op_byte <= 8'h02;
        i_panel.press();
        settle();
        chk("start no mode", 32'h0000_0000, 32'(n_cs - n0));
        @(posedge clk_i);
        cmd_r.op_byte <= 8'h21;
        settle();
        i_panel.press();
        wait_start();
        @(posedge clk_i) rstn_i <= 1'b0;
        settle();
        chk("idle in reset", 32'(ocd_pkg::MODE_NONE), 32'(mode));
        chk("feed in reset", 32'h0000_0000, 32'(fen));
        report_and_stop();
    end
endmodule
`default_nettype wire
